//--- design/dcls_top.sv
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module dcls_top (
  input  wire logic                  aclk,               // 250 MHz clock
  input  wire logic                  aresetn,            // sync reset, low
  input  wire logic [7:0]            s_axi_awaddr,       // write address
  input  wire logic                  s_axi_awvalid,      // write address valid
  output logic                       s_axi_awready,      // write address ready
  input  wire logic [31:0]           s_axi_wdata,        // write data
  input  wire logic [3:0]            s_axi_wstrb,        // byte strobes
  input  wire logic                  s_axi_wvalid,       // write data valid
  output logic                       s_axi_wready,       // write data ready
  output logic [1:0]                 s_axi_bresp,        // write response
  output logic                       s_axi_bvalid,       // write response valid
  input  wire logic                  s_axi_bready,       // write response ready
  input  wire logic [7:0]            s_axi_araddr,       // read address
  input  wire logic                  s_axi_arvalid,      // read address valid
  output logic                       s_axi_arready,      // read address ready
  output logic [31:0]                s_axi_rdata,        // read data
  output logic [1:0]                 s_axi_rresp,        // read response
  output logic                       s_axi_rvalid,       // read data valid
  input  wire logic                  s_axi_rready,       // read data ready
  input  wire logic                  op_valid,           // pipeline request
  input  wire dcls_pkg::dcls_op_req_t op_req,            // pipeline payload
  output logic                       op_ready,           // request taken
  output logic                       op_done,            // access finished
  output logic [31:0]                op_rdata,           // read result
  output logic                       mem_valid,          // memory word request
  output dcls_pkg::dcls_mem_req_t    mem_req,            // memory payload
  input  wire logic                  mem_ready,          // memory word done
  input  wire logic [31:0]           mem_rdata,          // memory read data
  input  wire logic                  snp_valid,          // alternate master access
  input  wire logic [31:0]           snp_addr,           // snooped address
  output logic                       snp_done,           // snoop handled
  input  wire logic                  cache_disable_in_n, // external disable, low
  output logic                       dc_enable,          // data cache in use
  output logic                       ic_enable,          // instruction cache in use
  output logic                       ic_invalidate       // instruction cache flush
);
  import dcls_pkg::*;

  // =====================================================
  // storage, not reset so contents survive reset
  dcls_tag_t        tag_mem [SETS];
  logic [1:0]       st_mem  [SETS];
  logic [3:0][31:0] dat_mem [SETS];

  logic [CTL_W-1:0] cache_control_register;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic [1:0]       ops_q;
  dcls_state_t      state_q;
  dcls_state_t      ret_q;
  dcls_op_req_t     req_q;
  logic [1:0]       wcnt_q;
  logic [6:0]       idx_q;
  logic [3:0][31:0] pbuf_q;
  logic [31:0]      pb_addr_q;
  logic             pend_q;
  logic             upd_q;
  logic             push_q;

  logic             wr_fire;
  logic             mem_hs;
  dcls_idx_t        ri;
  logic [1:0]       wi;
  logic [1:0]       lst;
  logic             hit;
  logic             cacheable;
  dcls_idx_t        si;
  logic             snp_hit;
  logic [1:0]       ost;

  function automatic dcls_mem_req_t mk(input logic w, input logic [31:0] a,
                                       input logic [31:0] d);
    dcls_mem_req_t r;
    r.write = w;
    r.addr  = a;
    r.wdata = d;
    return r;
  endfunction

  function automatic logic [31:0] base_of(input dcls_tag_t t, input dcls_idx_t i);
    return {t, i, LINE_OFS};
  endfunction

  // =====================================================
  // lookup
  assign ri        = idx_of(req_q.addr);
  assign wi        = wrd_of(req_q.addr);
  assign lst       = st_mem[ri];
  assign hit       = lst[ST_V] && (tag_mem[ri] == tag_of(req_q.addr));
  assign cacheable = dc_enable && !req_q.walk;
  assign si        = idx_of(snp_addr);
  assign snp_hit   = st_mem[si][ST_V] && (tag_mem[si] == tag_of(snp_addr));
  assign ost       = st_mem[idx_q];
  assign mem_hs    = mem_valid && mem_ready;
  assign wr_fire   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // =====================================================
  // register bus, write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready          <= 1'b1;
      s_axi_wready           <= 1'b1;
      s_axi_bvalid           <= 1'b0;
      s_axi_bresp            <= RESP_OK;
      awaddr_q               <= '0;
      wdata_q                <= '0;
      wstrb_q                <= '0;
      cache_control_register <= CTL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OK;
        if (awaddr_q == CTRL_OFS) begin
          if (wstrb_q[0]) begin
            cache_control_register <= wdata_q[CTL_W-1:0];
          end
        end else if (awaddr_q != OPS_OFS) begin
          s_axi_bresp <= RESP_ERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // =====================================================
  // register bus, read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OK;
      s_axi_rdata   <= '0;
      case (s_axi_araddr)
        CTRL_OFS: s_axi_rdata[CTL_W-1:0] <= cache_control_register;
        OPS_OFS:  s_axi_rdata[0] <= (ops_q != '0) || (state_q != S_IDLE);
        STAT_OFS: s_axi_rdata[1:0] <= {ic_enable, dc_enable};
        default:  s_axi_rresp <= RESP_ERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // =====================================================
  // line controller; arrays are written only outside reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= S_IDLE;
      ret_q         <= S_IDLE;
      req_q         <= '0;
      ops_q         <= '0;
      wcnt_q        <= '0;
      idx_q         <= '0;
      pbuf_q        <= '0;
      pb_addr_q     <= '0;
      pend_q        <= 1'b0;
      upd_q         <= 1'b0;
      push_q        <= 1'b0;
      op_ready      <= 1'b0;
      op_done       <= 1'b0;
      op_rdata      <= '0;
      mem_valid     <= 1'b0;
      mem_req       <= '0;
      snp_done      <= 1'b0;
      dc_enable     <= 1'b0;
      ic_enable     <= 1'b0;
      ic_invalidate <= 1'b0;
    end else begin
      op_ready      <= 1'b0;
      op_done       <= 1'b0;
      snp_done      <= 1'b0;
      ic_invalidate <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // enables only move between accesses
          dc_enable <= cache_control_register[CTL_DC] && cache_disable_in_n;
          ic_enable <= cache_control_register[CTL_IC] && cache_disable_in_n;
          if (op_valid && op_ready) begin
            req_q   <= op_req;
            state_q <= S_LOOK;
          end else if (snp_valid && !snp_done) begin
            if (snp_hit) begin
              st_mem[si] <= ST_INV;
            end
            snp_done <= 1'b1;
          end else if (ops_q != '0) begin
            // push goes first when both are asked for
            push_q <= ops_q[OPS_PUSH];
            if (ops_q[OPS_PUSH]) begin
              ops_q[OPS_PUSH] <= 1'b0;
            end else begin
              ops_q[OPS_INV] <= 1'b0;
              ic_invalidate  <= 1'b1;
            end
            idx_q   <= '0;
            state_q <= S_OPS;
          end else begin
            op_ready <= 1'b1;
          end
        end
        S_LOOK: begin
          if (!cacheable) begin
            mem_req   <= mk(req_q.write, req_q.addr, req_q.wdata);
            mem_valid <= 1'b1;
            upd_q     <= 1'b0;
            state_q   <= S_WORD;
          end else if (hit && !req_q.write) begin
            op_rdata <= dat_mem[ri][wi];
            op_done  <= 1'b1;
            state_q  <= S_IDLE;
          end else if (hit && cache_control_register[CTL_CB]) begin
            dat_mem[ri][wi] <= req_q.wdata;
            st_mem[ri]      <= ST_DRT;
            op_done         <= 1'b1;
            state_q         <= S_IDLE;
          end else if (!hit && (!req_q.write || cache_control_register[CTL_CB])) begin
            // miss that allocates; a dirty victim goes to the push buffer
            pend_q    <= lst == ST_DRT;
            pbuf_q    <= dat_mem[ri];
            pb_addr_q <= base_of(tag_mem[ri], ri);
            wcnt_q    <= '0;
            mem_req   <= mk(1'b0, {req_q.addr[31:IDX_LO], LINE_OFS}, '0);
            mem_valid <= 1'b1;
            state_q   <= S_FILL;
          end else if (hit && lst == ST_DRT) begin
            pbuf_q    <= dat_mem[ri];
            pb_addr_q <= base_of(tag_mem[ri], ri);
            wcnt_q    <= '0;
            mem_req   <= mk(1'b1, base_of(tag_mem[ri], ri), dat_mem[ri][0]);
            mem_valid <= 1'b1;
            upd_q     <= 1'b1;
            ret_q     <= S_WORD;
            state_q   <= S_DRAIN;
          end else begin
            mem_req   <= mk(1'b1, req_q.addr, req_q.wdata);
            mem_valid <= 1'b1;
            upd_q     <= hit;
            state_q   <= S_WORD;
          end
        end
        S_FILL: begin
          if (mem_hs) begin
            if (req_q.write && wcnt_q == wi) begin
              dat_mem[ri][wcnt_q] <= req_q.wdata;
            end else begin
              dat_mem[ri][wcnt_q] <= mem_rdata;
            end
            if (!req_q.write && wcnt_q == wi) begin
              op_rdata <= mem_rdata;
            end
            if (wcnt_q == WRD_LAST) begin
              tag_mem[ri] <= tag_of(req_q.addr);
              st_mem[ri]  <= req_q.write ? ST_DRT : ST_VAL;
              op_done     <= 1'b1;
              wcnt_q      <= '0;
              if (pend_q) begin
                // data is already delivered, the old line drains after
                mem_req <= mk(1'b1, pb_addr_q, pbuf_q[0]);
                ret_q   <= S_IDLE;
                state_q <= S_DRAIN;
              end else begin
                mem_valid <= 1'b0;
                state_q   <= S_IDLE;
              end
            end else begin
              wcnt_q  <= wcnt_q + 2'h1;
              mem_req <= mk(1'b0, {mem_req.addr[31:IDX_LO], wcnt_q + 2'h1, WRD_OFS}, '0);
            end
          end
        end
        S_DRAIN: begin
          if (mem_hs) begin
            if (wcnt_q == WRD_LAST) begin
              wcnt_q  <= '0;
              state_q <= ret_q;
              if (ret_q == S_WORD) begin
                mem_req <= mk(1'b1, req_q.addr, req_q.wdata);
              end else begin
                mem_valid <= 1'b0;
              end
            end else begin
              wcnt_q  <= wcnt_q + 2'h1;
              mem_req <= mk(1'b1, {pb_addr_q[31:IDX_LO], wcnt_q + 2'h1, WRD_OFS},
                            pbuf_q[wcnt_q + 2'h1]);
            end
          end
        end
        S_WORD: begin
          if (mem_hs) begin
            mem_valid <= 1'b0;
            if (!req_q.write) begin
              op_rdata <= mem_rdata;
            end
            if (upd_q) begin
              dat_mem[ri][wi] <= req_q.wdata;
              st_mem[ri]      <= ST_VAL;
            end
            op_done <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_OPS: begin
          idx_q   <= idx_q + 7'h1;
          state_q <= (idx_q == IDX_LAST) ? S_IDLE : S_OPS;
          if (!push_q || ost != ST_DRT) begin
            st_mem[idx_q] <= ST_INV;
          end else begin
            // dirty line under push: write it out, then resume the walk
            if (!cache_control_register[CTL_KEEP]) begin
              st_mem[idx_q] <= ST_INV;
            end
            pbuf_q    <= dat_mem[idx_q];
            pb_addr_q <= base_of(tag_mem[idx_q], idx_q);
            wcnt_q    <= '0;
            mem_req   <= mk(1'b1, base_of(tag_mem[idx_q], idx_q), dat_mem[idx_q][0]);
            mem_valid <= 1'b1;
            ret_q     <= (idx_q == IDX_LAST) ? S_IDLE : S_OPS;
            state_q   <= S_DRAIN;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
      // a new request on the same cycle as its service wins
      if (wr_fire && awaddr_q == OPS_OFS && wstrb_q[0]) begin
        if (wdata_q[OPS_INV]) begin
          ops_q[OPS_INV] <= 1'b1;
        end
        if (wdata_q[OPS_PUSH]) begin
          ops_q[OPS_PUSH] <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- shared/dcls_pkg.sv
package dcls_pkg;

  // =====================================================
  // geometry
  localparam int unsigned SETS   = 128;
  localparam int unsigned IDX_LO = 4;
  localparam int unsigned IDX_HI = 10;
  localparam int unsigned TAG_LO = 11;
  localparam int unsigned WRD_LO = 2;
  localparam logic [1:0]  WRD_LAST = 2'h3;
  localparam logic [6:0]  IDX_LAST = 7'h7f;
  localparam logic [3:0]  LINE_OFS = 4'h0;
  localparam logic [1:0]  WRD_OFS  = 2'h0;

  // =====================================================
  // line states: bit 0 valid, bit 1 dirty
  localparam int unsigned ST_V = 0;
  localparam logic [1:0]  ST_INV = 2'h0;
  localparam logic [1:0]  ST_VAL = 2'h1;
  localparam logic [1:0]  ST_DRT = 2'h3;

  // =====================================================
  // register map
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AW-1:0] OPS_OFS  = 8'h04;
  localparam logic [AW-1:0] STAT_OFS = 8'h08;
  localparam int unsigned CTL_DC   = 0;
  localparam int unsigned CTL_IC   = 1;
  localparam int unsigned CTL_KEEP = 2;
  localparam int unsigned CTL_CB   = 3;
  localparam int unsigned CTL_W    = 4;
  localparam logic [CTL_W-1:0] CTL_RST = 4'h0;
  localparam int unsigned OPS_INV  = 0;
  localparam int unsigned OPS_PUSH = 1;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef logic [6:0]  dcls_idx_t;
  typedef logic [20:0] dcls_tag_t;

  typedef struct packed {
    logic        write;
    logic        walk;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcls_op_req_t;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcls_mem_req_t;

  typedef enum logic [2:0] {
    S_IDLE, S_LOOK, S_FILL, S_DRAIN, S_WORD, S_OPS
  } dcls_state_t;

  function automatic dcls_idx_t idx_of(input logic [31:0] a);
    return a[IDX_HI:IDX_LO];
  endfunction

  function automatic dcls_tag_t tag_of(input logic [31:0] a);
    return a[31:TAG_LO];
  endfunction

  function automatic logic [1:0] wrd_of(input logic [31:0] a);
    return a[IDX_LO-1:WRD_LO];
  endfunction

endpackage

//--- verif/dcls_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// memory side model, random or slow word latency
module dcls_mem_model (
  input  wire logic                    aclk,      // clock
  input  wire logic                    mem_valid, // word request
  input  wire dcls_pkg::dcls_mem_req_t mem_req,   // request payload
  output logic                         mem_ready, // word done
  output logic [31:0]                  mem_rdata, // read data
  input  wire logic                    slow       // long waits
);
  import dcls_pkg::*;
  logic [31:0] mem [logic [31:0]];
  int unsigned n_tx = 0;
  int unsigned wait_q = 0;
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'h5a5a0000;
  endfunction
  initial begin
    mem_ready = 1'b0;
    mem_rdata = 32'h0;
  end
  // read data is scrambled whenever no word is being returned
  always @(posedge aclk) begin
    if (mem_valid && mem_ready) begin
      n_tx++;
      if (mem_req.write) mem[mem_req.addr] = mem_req.wdata;
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_valid && wait_q == 0) begin
      mem_ready <= 1'b1;
      mem_rdata <= mem_req.write ? ~mem_rdata : peek(mem_req.addr);
      wait_q = slow ? 6 : $urandom_range(2);
    end else if (mem_valid) begin
      wait_q--;
    end
  end
endmodule
`default_nettype wire

//--- verif/dcls_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// port checker
module dcls_checker (
  input wire logic                    aclk,               // clock
  input wire logic                    aresetn,            // reset, low
  input wire logic                    s_axi_bvalid,       // write response valid
  input wire logic                    s_axi_bready,       // write response ready
  input wire logic [1:0]              s_axi_bresp,        // write response
  input wire logic                    op_valid,           // pipeline request
  input wire logic                    op_ready,           // request taken
  input wire logic                    op_done,            // access finished
  input wire logic                    mem_valid,          // memory request
  input wire dcls_pkg::dcls_mem_req_t mem_req,            // memory payload
  input wire logic                    mem_ready,          // memory done
  input wire logic                    snp_valid,          // snoop request
  input wire logic                    snp_done,           // snoop handled
  input wire logic                    cache_disable_in_n, // disable, low
  input wire logic                    dc_enable,          // data cache on
  input wire logic                    ic_enable,          // instr cache on
  input wire logic                    ic_invalidate       // instr flush
);
  import dcls_pkg::*;
  default clocking cb_clk @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    !aresetn |=> !dc_enable && !ic_enable && !mem_valid && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  AST_CACHE_DISABLE_IN_N_OFF: assert property (
    op_ready && !cache_disable_in_n |=> !dc_enable && !ic_enable)
    else $error("cache enabled while disable input low");
  AST_ENABLE_HELD: assert property (
    mem_valid && $past(mem_valid) |-> $stable(dc_enable) && $stable(ic_enable))
    else $error("enable changed during an access");
  AST_MEM_HOLD: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("memory request dropped before done");
  AST_MEM_ALIGN: assert property (
    mem_valid |-> mem_req.addr[1:0] == 2'h0)
    else $error("memory address not word aligned");
  AST_TAKE_BUSY: assert property (
    op_valid && op_ready |=> !op_ready ##1 !op_ready)
    else $error("ready too soon after take");
  AST_SNP_DONE: assert property (
    snp_valid && !snp_done && op_ready && !op_valid |-> ##[1:4] snp_done)
    else $error("snoop not answered");
  AST_DONE_PULSE: assert property (
    op_done |=> !op_done)
    else $error("done longer than one cycle");
  AST_ICINV_PULSE: assert property (
    ic_invalidate |=> !ic_invalidate)
    else $error("instr flush longer than one cycle");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind dcls_top dcls_checker dcls_checker_inst (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .op_valid,
  .op_ready, .op_done, .mem_valid, .mem_req, .mem_ready, .snp_valid, .snp_done,
  .cache_disable_in_n, .dc_enable, .ic_enable, .ic_invalidate);
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dcls_pkg::*;
  localparam int LIM = 400;
  logic aclk = 0, aresetn = 0, slow = 0, cache_disable_in_n = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, op_valid = 0, snp_valid = 0;
  logic [31:0] s_axi_wdata = 0, snp_addr = 0, op_rdata, mem_rdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic op_ready, op_done, mem_valid, mem_ready, snp_done;
  logic dc_enable, ic_enable, ic_invalidate;
  dcls_op_req_t op_req = '0;
  dcls_mem_req_t mem_req;
  int n_errors = 0, total_checks = 0, ex = 0, n_ic = 0;
  logic [31:0] rm [logic [31:0]];
  logic [1:0] st [SETS];
  logic [20:0] tg [SETS];
  logic [31:0] dt [SETS*4];
  logic [3:0] ctl = 4'h0;
  logic dis = 0;
  dcls_top dcls_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_req, .op_ready, .op_done,
    .op_rdata, .mem_valid, .mem_req, .mem_ready, .mem_rdata, .snp_valid, .snp_addr,
    .snp_done, .cache_disable_in_n, .dc_enable, .ic_enable, .ic_invalidate);
  dcls_mem_model dcls_mem_model_inst (.aclk, .mem_valid, .mem_req, .mem_ready,
    .mem_rdata, .slow);
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) if (ic_invalidate === 1'b1) n_ic++;
  // ========
  // reporting
  task automatic end_of_test;
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo;
    n_errors++;
    end_of_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int s);
    int n;
    for (n = 0; n < LIM; n++) begin
      @(posedge aclk);
      if ((s == 0 ? op_ready : s == 1 ? op_done : snp_done) === 1'b1) break;
    end
    if (n == LIM) tmo();
  endtask
  // ========
  // register bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == LIM) tmo();
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == LIM) tmo();
    d = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // ========
  // reference model of lines and memory
  function automatic logic [31:0] rd(input logic [31:0] a);
    return rm.exists(a) ? rm[a] : a ^ 32'h5a5a0000;
  endfunction
  task automatic wb(input int i);
    for (int w = 0; w < 4; w++) rm[{tg[i], i[6:0], w[1:0], 2'h0}] = dt[i*4+w];
    ex += 4;
  endtask
  task automatic fill(input int i, input logic [31:0] a);
    for (int w = 0; w < 4; w++) dt[i*4+w] = rd({a[31:4], w[1:0], 2'h0});
    tg[i] = a[31:TAG_LO];
    ex += 4;
  endtask
  task automatic mdl_op(input logic w, wk, input logic [31:0] a, d, output logic [31:0] e);
    int i, o;
    logic hit;
    i = a[IDX_HI:IDX_LO];
    o = i * 4 + a[3:2];
    hit = st[i][ST_V] === 1'b1 && tg[i] === a[31:TAG_LO];
    ex = 0;
    e = 32'h0;
    if (!ctl[CTL_DC] || dis || wk) begin
      if (w) rm[a] = d;
      else e = rd(a);
      ex = 1;
    end else if (!w) begin
      if (!hit && st[i] === ST_DRT) wb(i);
      if (!hit) fill(i, a);
      if (!hit) st[i] = ST_VAL;
      e = dt[o];
    end else if (ctl[CTL_CB]) begin
      if (!hit && st[i] === ST_DRT) wb(i);
      if (!hit) fill(i, a);
      dt[o] = d;
      st[i] = ST_DRT;
    end else begin
      if (hit && st[i] === ST_DRT) wb(i);
      if (hit) dt[o] = d;
      if (hit) st[i] = ST_VAL;
      rm[a] = d;
      ex += 1;
    end
  endtask
  // ========
  // stimulus tasks
  task automatic do_op(input logic w, wk, input logic [31:0] a, d, input logic ds);
    logic [31:0] e;
    int t0;
    mdl_op(w, wk, a, d, e);
    t0 = dcls_mem_model_inst.n_tx;
    op_req <= '{w, wk, a, d};
    op_valid <= 1'b1;
    wt(0);
    op_valid <= 1'b0;
    if (ds) cache_disable_in_n <= 1'b0;
    wt(1);
    if (!w) chk("op_rdata", e, op_rdata);
    wt(0);
    chk("mem_tx", ex, dcls_mem_model_inst.n_tx - t0);
  endtask
  task automatic snoop(input logic [31:0] a);
    int i;
    i = a[IDX_HI:IDX_LO];
    if (st[i][ST_V] === 1'b1 && tg[i] === a[31:TAG_LO]) st[i] = ST_INV;
    snp_addr <= a;
    snp_valid <= 1'b1;
    wt(2);
    snp_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic chk_en;
    repeat (2) @(posedge aclk);
    chk("enables", {30'h0, ctl[CTL_IC] && !dis, ctl[CTL_DC] && !dis},
        {30'h0, ic_enable, dc_enable});
  endtask
  task automatic set_ctrl(input logic [3:0] v);
    logic [31:0] r;
    ctl = v;
    axi_wr(CTRL_OFS, {28'h0, v}, RESP_OK);
    axi_rd(CTRL_OFS, r, RESP_OK);
    chk("ctrl", {28'h0, v}, r);
    chk_en();
  endtask
  task automatic cache_op(input logic [1:0] v);
    int n, t0, ic0;
    logic [31:0] r;
    t0 = dcls_mem_model_inst.n_tx;
    ic0 = n_ic;
    ex = 0;
    for (int i = 0; i < SETS; i++) begin
      if (v[OPS_PUSH] && st[i] === ST_DRT) wb(i);
      if (v[OPS_INV] || (v[OPS_PUSH] && !(ctl[CTL_KEEP] && st[i] === ST_DRT))) st[i] = ST_INV;
    end
    axi_wr(OPS_OFS, {30'h0, v}, RESP_OK);
    for (n = 0; n < LIM; n++) begin
      axi_rd(OPS_OFS, r, RESP_OK);
      if (r[0] === 1'b0) break;
    end
    if (n == LIM) tmo();
    chk("push_tx", ex, dcls_mem_model_inst.n_tx - t0);
    chk("ic_flush", v[OPS_INV], n_ic - ic0);
  endtask
  // small tag and index pool, index 127 as the top boundary
  function automatic logic [31:0] raddr();
    logic [6:0] ix;
    ix = ($urandom_range(2) == 2) ? IDX_LAST : 7'($urandom_range(1));
    return {19'h0, 2'($urandom_range(2)), ix, 2'($urandom_range(3)), 2'h0};
  endfunction
  task automatic run(input int n, input bit sn);
    logic [31:0] a;
    for (int k = 0; k < n; k++) begin
      a = raddr();
      if (sn && $urandom_range(7) == 0) snoop(a);
      else do_op(1'($urandom_range(1)), $urandom_range(7) == 0, a, $urandom, 1'b0);
    end
  endtask
  // ========
  // main sequence
  initial begin
    logic [31:0] r;
    void'($urandom(25));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(CTRL_OFS, r, RESP_OK);
    chk("ctrl", 32'h0, r);
    axi_rd(STAT_OFS, r, RESP_OK);
    chk("stat", 32'h0, r);
    axi_rd(8'hfc, r, RESP_ERR);
    axi_wr(8'hf0, 32'h1, RESP_ERR);
    cache_op(2'h1);
    set_ctrl(4'hb);
    run(60, 1'b1);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    ctl = 4'h0;
    chk_en();
    cache_op(2'h2);
    cache_op(2'h1);
    set_ctrl(4'h3);
    run(60, 1'b1);
    set_ctrl(4'hf);
    run(40, 1'b1);
    cache_op(2'h2);
    run(20, 1'b1);
    cache_op(2'h3);
    set_ctrl(4'hb);
    run(20, 1'b1);
    slow <= 1'b1;
    do_op(1'b0, 1'b0, 32'h00001840, 32'h0, 1'b1);
    dis = 1'b1;
    slow <= 1'b0;
    chk_en();
    run(30, 1'b0);
    cache_disable_in_n <= 1'b1;
    dis = 1'b0;
    chk_en();
    do_op(1'b0, 1'b0, 32'h00001840, 32'h0, 1'b0);
    run(20, 1'b1);
    foreach (rm[a]) chk("memory", rm[a], dcls_mem_model_inst.peek(a));
    end_of_test();
  end
endmodule
`default_nettype wire
